// file: hdl/swctl_map.vh
// How it works
// [R1] Holding reset low returns the device registers to defaults.
// [R2] Reset pin idles high; pulsed low only to reset.
// [R3] After reset, device defaults follow the parallel pins.
// [R4] Pins rule until first serial access, then ignored till reset.
// [R5] Start: data falls while clock is high.
// [R6] Address 1001 plus three select bits, MSB first.
// [R7] Write direction bit is 0; device acknowledges matching address.
// [R8] Eight-bit register pointer follows, MSB first, acknowledged.
// [R9] One data byte follows, MSB first, stored and acknowledged.
// [R10] Stop: data rises while clock high; bus released, device idles.
// [R11] Repeated start may replace stop; address decoded afresh.
// [R12] Read: pointer write, repeated start, same address, direction 1.
// [R13] Device returns eight register bits MSB first.
// [R14] Master acknowledges read byte, then stop or repeated start.
// [R15] Pointer kept across repeated start for pointerless reads.
// [R16] Serial write takes effect after delay from last data bit fall.
// [R17] Parallel change starts delay at the pin transition.
// [R18] Writes inside open window replace pending values, no restart.
// [R19] Write after window closes applies at once, opens new window.
// [R20] Parallel pins set parallel register values while active.
// [R21] After channel pin change, controller pulses reset low.
// [R22] Update delays are configurable cycle-count parameters; the device model's UPD_NS gives its delay in ns, not cycles.
`ifndef SWCTL_MAP_VH
`define SWCTL_MAP_VH
`define SWCTL_ADDR_HIGH      4'h9
`define SWCTL_DIR_WRITE      1'b0
`define SWCTL_DIR_READ       1'b1
`define SWCTL_CLK_NS         8
`define SWCTL_SCL_PERIOD_NS  10000
`define SWCTL_SCL_QUARTER    ((`SWCTL_SCL_PERIOD_NS / 4) / `SWCTL_CLK_NS)
`define SWCTL_RST_PULSE_NS   1000
`define SWCTL_RST_CYCLES     ((`SWCTL_RST_PULSE_NS + `SWCTL_CLK_NS - 1) / `SWCTL_CLK_NS)
`define SWCTL_REG_CMD        4'h0
`define SWCTL_REG_STATUS     4'h1
`define SWCTL_REG_RDATA      4'h2
`define SWCTL_REG_PINS       4'h3
`define SWCTL_CMD_GO         0
`define SWCTL_CMD_READ       1
`define SWCTL_CMD_NOPTR      2
`define SWCTL_CMD_RSTART     3
`define SWCTL_CMD_RESET      4
`define SWCTL_ST_BUSY        0
`define SWCTL_ST_NACK        1
`define SWCTL_ST_SERIAL      2
`define SWCTL_PINS_RESET     8'h80
`endif

// file: hdl/swctl_sync.v
`timescale 1ns/10ps
`default_nettype none
module swctl_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input  wire             clk_in,
    input  wire             reset_n_in,
    // Asynchronous in, synchronous out.
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_reg <= {WIDTH{1'b1}};
            stage2_reg <= {WIDTH{1'b1}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule // swctl_sync
`default_nettype wire

// file: hdl/swctl_rstgen.v
`timescale 1ns/10ps
`default_nettype none
`include "swctl_map.vh"
module swctl_rstgen #(
    parameter CYCLES = `SWCTL_RST_CYCLES
) (
    // Clock and reset.
    input  wire clk_in,
    input  wire reset_n_in,
    // Request and pin.
    input  wire start_in,
    output wire busy_out,
    output reg  dev_reset_n_out
);
    reg [15:0] count_reg;

    // The pin idles high and is only pulled low on request. [R2] [R21]
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg       <= 16'h0000;
            dev_reset_n_out <= 1'b1;
        end else if (start_in && count_reg == 16'h0000) begin
            count_reg       <= CYCLES[15:0];
            dev_reset_n_out <= 1'b0;
        end else if (count_reg != 16'h0000) begin
            count_reg       <= count_reg - 16'h0001;
            dev_reset_n_out <= (count_reg == 16'h0001);
        end
    end

    assign busy_out = (count_reg != 16'h0000);
endmodule // swctl_rstgen
`default_nettype wire

// file: hdl/swctl_host.v
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "swctl_map.vh"
module swctl_host #(
    parameter QUARTER    = `SWCTL_SCL_QUARTER,
    parameter RST_CYCLES = `SWCTL_RST_CYCLES
) (
    // Clock and reset.
    input  wire       clk_in,
    input  wire       reset_n_in,
    // Software port.
    input  wire [3:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output reg  [7:0] rdata_out,
    // Serial bus.
    input  wire       scl_in,
    output wire       scl_out,
    output wire       scl_oe_out,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_out,
    // Device straps and parallel pins.
    output reg  [2:0] slave_addr_select_out,
    output reg        parallel_output_enable_pin_out,
    output reg  [1:0] parallel_channel_select_pins_out,
    output reg        parallel_equalizer_level_pin_out,
    output reg  [1:0] parallel_preemphasis_pins_out,
    output reg        parallel_output_termination_pin_out,
    output reg        parallel_output_current_pin_out,
    output wire       dev_reset_n_out
);
    ////////////////////////////////////////////////////////////////////
    localparam S_IDLE  = 10'h001;
    localparam S_START = 10'h002;
    localparam S_BYTE  = 10'h004;
    localparam S_ACK   = 10'h008;
    localparam S_RBYTE = 10'h010;
    localparam S_MACK  = 10'h020;
    localparam S_STOP  = 10'h040;
    localparam S_RSTRT = 10'h080;
    localparam S_DONE  = 10'h100;
    localparam S_RSETW = 10'h200;

    reg [9:0]  state_reg;
    reg [15:0] tick_reg;
    reg [1:0]  phase_reg;
    reg [2:0]  bit_reg;
    reg [1:0]  byte_reg;
    reg [7:0]  shift_reg;
    reg        scl_low_reg;
    reg        sda_low_reg;
    reg [7:0]  ptr_reg;
    reg [7:0]  data_reg;
    reg        read_reg;
    reg        noptr_reg;
    reg        rstart_reg;
    reg        in_read_reg;
    reg        nack_reg;
    reg        serial_used_reg;
    reg [7:0]  rbyte_reg;
    reg [7:0]  pins_reg;
    reg        rst_req_reg;
    wire       scl_s;
    wire       sda_s;
    wire       rst_busy;
    wire       tick;
    wire [6:0] slave_addr;

    swctl_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({scl_in, sda_in}),
        .sync_out   ({scl_s, sda_s})
    );

    swctl_rstgen #(
        .CYCLES (RST_CYCLES)
    ) u_rst (
        .clk_in          (clk_in),
        .reset_n_in      (reset_n_in),
        .start_in        (rst_req_reg),
        .busy_out        (rst_busy),
        .dev_reset_n_out (dev_reset_n_out)
    );

    // Open drain: we only ever pull low, the pull-up raises the line.
    assign scl_out    = 1'b0;
    assign scl_oe_out = scl_low_reg;
    assign sda_out    = 1'b0;
    assign sda_oe_out = sda_low_reg;

    assign slave_addr = {`SWCTL_ADDR_HIGH, slave_addr_select_out}; // [R6]
    // A stretched clock holds the high quarter until the line really rises.
    assign tick = (tick_reg == 16'h0000) && !(phase_reg == 2'd2 && !scl_s);

    ////////////////////////////////////////////////////////////////////
    // Software registers. Pin changes land on the pins directly; the
    // device starts its own update delay on each pin edge. [R17] [R20]
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pins_reg    <= `SWCTL_PINS_RESET;
            rst_req_reg <= 1'b0;
            rdata_out   <= 8'h00;
        end else begin
            rst_req_reg <= 1'b0;
            if (wr_in && addr_in == `SWCTL_REG_PINS) begin
                pins_reg <= wdata_in;
                // Channel select is only taken after a device reset. [R21]
                if (wdata_in[6:5] != pins_reg[6:5])
                    rst_req_reg <= 1'b1;
            end else if (wr_in && addr_in == `SWCTL_REG_STATUS
                         && wdata_in[`SWCTL_CMD_RESET]) begin
                rst_req_reg <= 1'b1; // [R1]
            end
            if (rd_in) begin
                if (addr_in == `SWCTL_REG_STATUS)
                    rdata_out <= {5'h00, serial_used_reg, nack_reg,
                                  state_reg != S_IDLE || rst_busy};
                else if (addr_in == `SWCTL_REG_RDATA)
                    rdata_out <= rbyte_reg;
                else if (addr_in == `SWCTL_REG_PINS)
                    rdata_out <= pins_reg;
                else if (addr_in == `SWCTL_REG_CMD)
                    rdata_out <= ptr_reg;
                else
                    rdata_out <= 8'h00;
            end
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            slave_addr_select_out               <= 3'h0;
            parallel_output_enable_pin_out      <= 1'b1;
            parallel_channel_select_pins_out    <= 2'h0;
            parallel_equalizer_level_pin_out    <= 1'b0;
            parallel_preemphasis_pins_out       <= 2'h0;
            parallel_output_termination_pin_out <= 1'b0;
            parallel_output_current_pin_out     <= 1'b0;
        end else begin
            slave_addr_select_out               <= pins_reg[2:0];
            parallel_output_enable_pin_out      <= pins_reg[7];
            parallel_channel_select_pins_out    <= pins_reg[6:5];
            parallel_equalizer_level_pin_out    <= pins_reg[4];
            parallel_preemphasis_pins_out       <= {pins_reg[3], 1'b0};
            parallel_output_termination_pin_out <= 1'b0;
            parallel_output_current_pin_out     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transaction engine. Each bit is four quarters: low, rise, high, fall.
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg       <= S_IDLE;
            tick_reg        <= 16'h0000;
            phase_reg       <= 2'd0;
            bit_reg         <= 3'd0;
            byte_reg        <= 2'd0;
            shift_reg       <= 8'h00;
            scl_low_reg     <= 1'b0;
            sda_low_reg     <= 1'b0;
            ptr_reg         <= 8'h00;
            data_reg        <= 8'h00;
            read_reg        <= 1'b0;
            noptr_reg       <= 1'b0;
            rstart_reg      <= 1'b0;
            in_read_reg     <= 1'b0;
            nack_reg        <= 1'b0;
            serial_used_reg <= 1'b0;
            rbyte_reg       <= 8'h00;
        end else begin
            if (tick_reg != 16'h0000)
                tick_reg <= tick_reg - 16'h0001;
            else if (tick)
                tick_reg <= QUARTER[15:0];
            if (rst_req_reg)
                serial_used_reg <= 1'b0; // [R4]
            if (wr_in && addr_in == `SWCTL_REG_CMD && state_reg == S_IDLE) begin
                ptr_reg <= wdata_in;
            end
            case (state_reg)
            S_IDLE: begin
                if (wr_in && addr_in == `SWCTL_REG_RDATA)
                    data_reg <= wdata_in;
                if (wr_in && addr_in == `SWCTL_REG_STATUS && !rst_busy
                    && wdata_in[`SWCTL_CMD_GO]) begin
                    read_reg    <= wdata_in[`SWCTL_CMD_READ];
                    noptr_reg   <= wdata_in[`SWCTL_CMD_NOPTR];
                    rstart_reg  <= wdata_in[`SWCTL_CMD_RSTART];
                    nack_reg    <= 1'b0;
                    in_read_reg <= 1'b0;
                    phase_reg   <= 2'd0;
                    state_reg   <= S_START;
                end
            end
            S_START: if (tick) begin
                // Data falls with the clock high, then the clock falls. [R5]
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0) begin
                    sda_low_reg <= 1'b1;
                end else if (phase_reg == 2'd1) begin
                    scl_low_reg <= 1'b1;
                    bit_reg     <= 3'd7;
                    byte_reg    <= 2'd0;
                    phase_reg   <= 2'd0;
                    // Read without pointer goes straight to the read
                    // address; the device keeps its pointer. [R12] [R15]
                    in_read_reg <= read_reg && noptr_reg;
                    shift_reg   <= {slave_addr, (read_reg && noptr_reg)
                                    ? `SWCTL_DIR_READ : `SWCTL_DIR_WRITE};
                    state_reg   <= S_BYTE; // [R7]
                    serial_used_reg <= 1'b1; // [R4]
                end
            end
            S_BYTE: if (tick) begin
                // MSB first on every byte. [R6] [R8] [R9]
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0)
                    sda_low_reg <= !shift_reg[7];
                else if (phase_reg == 2'd1)
                    scl_low_reg <= 1'b0;
                else if (phase_reg == 2'd3) begin
                    scl_low_reg <= 1'b1; // Delay starts here for data. [R16]
                    shift_reg   <= {shift_reg[6:0], 1'b0};
                    bit_reg     <= bit_reg - 3'd1;
                    if (bit_reg == 3'd0)
                        state_reg <= S_ACK;
                end
            end
            S_ACK: if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0)
                    sda_low_reg <= 1'b0;
                else if (phase_reg == 2'd1)
                    scl_low_reg <= 1'b0;
                else if (phase_reg == 2'd2)
                    nack_reg <= sda_s;
                else begin
                    scl_low_reg <= 1'b1;
                    bit_reg     <= 3'd7;
                    byte_reg    <= byte_reg + 2'd1;
                    if (nack_reg)
                        state_reg <= S_STOP;
                    else if (in_read_reg)
                        state_reg <= S_RBYTE; // [R13]
                    else if (byte_reg == 2'd0) begin
                        shift_reg <= ptr_reg; // [R8]
                        state_reg <= S_BYTE;
                    end else if (byte_reg == 2'd1 && !read_reg) begin
                        shift_reg <= data_reg; // [R9]
                        state_reg <= S_BYTE;
                    end else if (byte_reg == 2'd1) begin
                        in_read_reg <= 1'b1;
                        state_reg   <= S_RSTRT; // [R12]
                    end else
                        state_reg <= rstart_reg ? S_RSTRT : S_STOP;
                end
            end
            S_RBYTE: if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0)
                    sda_low_reg <= 1'b0;
                else if (phase_reg == 2'd1)
                    scl_low_reg <= 1'b0;
                else if (phase_reg == 2'd2)
                    shift_reg <= {shift_reg[6:0], sda_s};
                else begin
                    scl_low_reg <= 1'b1;
                    bit_reg     <= bit_reg - 3'd1;
                    if (bit_reg == 3'd0)
                        state_reg <= S_MACK;
                end
            end
            S_MACK: if (tick) begin
                // Acknowledge the byte, then stop or repeated start. [R14]
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0) begin
                    sda_low_reg <= 1'b1;
                    rbyte_reg   <= shift_reg;
                end else if (phase_reg == 2'd1)
                    scl_low_reg <= 1'b0;
                else if (phase_reg == 2'd3) begin
                    scl_low_reg <= 1'b1;
                    state_reg   <= rstart_reg ? S_RSTRT : S_STOP;
                end
            end
            S_RSTRT: if (tick) begin
                // Release data, raise clock; start again only after a read's pointer byte, else done. [R11]
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0)
                    sda_low_reg <= 1'b0;
                else if (phase_reg == 2'd1) begin
                    scl_low_reg <= 1'b0;
                    phase_reg   <= 2'd0;
                    if (in_read_reg && byte_reg == 2'd2) begin
                        noptr_reg <= 1'b1;
                        state_reg <= S_START;
                    end else
                        state_reg <= S_DONE;
                end
            end
            S_STOP: if (tick) begin
                // Data rises while the clock is high. [R10]
                phase_reg <= phase_reg + 2'd1;
                if (phase_reg == 2'd0)
                    sda_low_reg <= 1'b1;
                else if (phase_reg == 2'd1)
                    scl_low_reg <= 1'b0;
                else if (phase_reg == 2'd2) begin
                    sda_low_reg <= 1'b0;
                    state_reg   <= S_DONE;
                end
            end
            S_DONE: begin
                phase_reg <= 2'd0;
                state_reg <= S_RSETW;
            end
            S_RSETW: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // swctl_host
`default_nettype wire

// file: tb/swctl_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
module swctl_host_chk #(
    parameter QUARTER    = 4,
    parameter RST_CYCLES = 4
) (
    // Clock and reset.
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    // Software port.
    input wire logic [3:0] addr_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // Bus and device pins.
    input wire logic       scl_oe_out,
    input wire logic       sda_oe_out,
    input wire logic [2:0] slave_addr_select_out,
    input wire logic       parallel_output_enable_pin_out,
    input wire logic [1:0] parallel_channel_select_pins_out,
    input wire logic       dev_reset_n_out
);
    logic [7:0] low_cnt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // Cycles the device reset has been low.
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            low_cnt <= 8'h00;
        end else if (!dev_reset_n_out) begin
            low_cnt <= low_cnt + 8'h01;
        end else begin
            low_cnt <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // A data edge with the clock released is a start or a stop.
    sequence s_start;
        $rose(sda_oe_out) && !scl_oe_out;
    endsequence
    sequence s_stop;
        $fell(sda_oe_out) && !scl_oe_out;
    endsequence

    a_start_clock: assert property (s_start |-> ##[1:16] scl_oe_out)
        else $error("start not followed by a clock low phase");
    a_stop_idle: assert property (s_stop |=> (!scl_oe_out && !sda_oe_out)[*4])
        else $error("bus not left released after stop");
    a_clk_low_len: assert property ($rose(scl_oe_out) |->
        scl_oe_out[*4] ##[1:40] !scl_oe_out)
        else $error("clock low phase has wrong length");
    a_clk_high_len: assert property ($fell(scl_oe_out) |-> !scl_oe_out[*4])
        else $error("clock high phase too short");
    a_chan_resets: assert property ($changed(parallel_channel_select_pins_out)
        |-> ##[0:3] !dev_reset_n_out)
        else $error("channel change without device reset pulse");
    a_rst_width: assert property ($rose(dev_reset_n_out) |-> low_cnt == RST_CYCLES)
        else $error("device reset pulse has wrong width");
    a_rst_bounded: assert property (low_cnt <= RST_CYCLES)
        else $error("device reset held low too long");
    a_pins_write: assert property ($changed({parallel_output_enable_pin_out,
        parallel_channel_select_pins_out, slave_addr_select_out})
        |-> $past(wr_in, 2) && $past(addr_in, 2) == 4'h3)
        else $error("parallel pins moved without a pin write");
    a_rdata_hold: assert property ($changed(rdata_out) |-> $past(rd_in))
        else $error("read data moved without a read");
endmodule // swctl_host_chk

bind swctl_host swctl_host_chk #(
    .QUARTER    (QUARTER),
    .RST_CYCLES (RST_CYCLES)
) swctl_host_chk_inst (
    .clk_in                           (clk_in),
    .reset_n_in                       (reset_n_in),
    .addr_in                          (addr_in),
    .wr_in                            (wr_in),
    .rd_in                            (rd_in),
    .rdata_out                        (rdata_out),
    .scl_oe_out                       (scl_oe_out),
    .sda_oe_out                       (sda_oe_out),
    .slave_addr_select_out            (slave_addr_select_out),
    .parallel_output_enable_pin_out   (parallel_output_enable_pin_out),
    .parallel_channel_select_pins_out (parallel_channel_select_pins_out),
    .dev_reset_n_out                  (dev_reset_n_out)
);
`default_nettype wire

// file: tb/swctl_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module swctl_dev_model (
    // Bus wires.
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_oe_out,
    // Straps, parallel pins and reset.
    input  wire logic [2:0] select_in,
    input  wire logic       enable_in,
    input  wire logic [1:0] chan_in,
    input  wire logic       reset_n_in
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic       act = 1'b0;
    logic       used = 1'b0;
    int         bitn = 0;
    int         phase = 0;
    parameter int UPD_NS = 2000;
    logic [7:0] live;

    initial sda_oe_out = 1'b0;

    always @(reset_n_in or enable_in or chan_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < 256; i++) mem[i] = 8'h00;
            used = 1'b0;
            act = 1'b0;
            sda_oe_out = 1'b0;
        end
        if (!reset_n_in || !used) begin
            mem[0] = {1'b0, enable_in, 4'h0, chan_in};
        end
    end
    always @(mem[0]) begin
        live = mem[0];
        #UPD_NS live = mem[0];
    end

    ////////////////////////////////////////////////////////////////////
    always @(negedge sda_in) if (scl_in === 1'b1 && reset_n_in) begin
        act = 1'b1;
        used = 1'b1;
        bitn = 0;
        phase = 0;
    end
    always @(posedge sda_in) if (scl_in === 1'b1) act = 1'b0;
    always @(posedge scl_in) if (act) begin
        sh = {sh[6:0], sda_in};
        bitn++;
    end
    // The pointer never advances; the line is let go after the ack.
    always @(negedge scl_in) if (act) begin
        sda_oe_out = 1'b0;
        if (bitn == 9) bitn = 0;
        if (bitn == 8) begin
            sda_oe_out = (phase < 3);
            case (phase)
                0: if (sh[7:1] === {4'h9, select_in}) begin
                    phase = sh[0] ? 3 : 1;
                end else begin
                    act = 1'b0;
                    sda_oe_out = 1'b0;
                end
                1: begin
                    ptr = sh;
                    phase = 2;
                end
                2: mem[ptr] = sh;
                3: phase = 4;
                default: sda_oe_out = 1'b0;
            endcase
        end else if (phase == 3) begin
            sda_oe_out = ~mem[ptr][7 - bitn];
        end
    end
endmodule // swctl_dev_model
`default_nettype wire

// file: tb/switch_control_interface_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module switch_control_interface_tb_top;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] ptr;
        logic [7:0] val;
    } swctl_row_t;

    logic       clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic [2:0] flip = 3'h0;
    logic [7:0] s;
    wire  [7:0] rdata_out;
    wire        scl_oe, sda_oe, dev_oe, dev_rst_n, en;
    wire  [2:0] sel;
    wire  [1:0] ch;
    wire        scl_w = ~scl_oe;
    wire        sda_w = ~(sda_oe | dev_oe);
    int         miscompares = 0;
    int         checked = 0;
    // Ops: 0 write, 1 read, 2 read at the kept pointer.
    swctl_row_t rows [0:6] = '{'{2'h0, 8'h10, 8'hA5}, '{2'h0, 8'h13, 8'h3C},
        '{2'h1, 8'h10, 8'hA5}, '{2'h2, 8'h00, 8'hA5}, '{2'h0, 8'hFF, 8'h5A},
        '{2'h1, 8'h13, 8'h3C}, '{2'h1, 8'hFF, 8'h5A}};

    always #4 clk_in = ~clk_in;

    swctl_host #(.QUARTER(4), .RST_CYCLES(4)) swctl_host_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .scl_in(scl_w), .scl_out(),
        .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(),
        .sda_oe_out(sda_oe), .slave_addr_select_out(sel),
        .parallel_output_enable_pin_out(en),
        .parallel_channel_select_pins_out(ch),
        .parallel_equalizer_level_pin_out(),
        .parallel_preemphasis_pins_out(),
        .parallel_output_termination_pin_out(),
        .parallel_output_current_pin_out(), .dev_reset_n_out(dev_rst_n));
    swctl_dev_model swctl_dev_model_inst (
        .scl_in(scl_w), .sda_in(sda_w), .sda_oe_out(dev_oe),
        .select_in(sel ^ flip), .enable_in(en), .chan_in(ch),
        .reset_n_in(dev_rst_n));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] got,
                       input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // One bus transfer; final status lands in s.
    task automatic xfer(input logic [1:0] op, input logic [7:0] ptr,
                        input logic [7:0] val);
        int n;
        n = 0;
        if (op != 2'h2) wr(4'h0, ptr);
        if (op == 2'h0) wr(4'h2, val);
        wr(4'h1, (op == 2'h0) ? 8'h01 : (op == 2'h1) ? 8'h03 : 8'h07);
        repeat (4) @(posedge clk_in);
        rd(4'h1, s);
        while (s[0] !== 1'b0 && n < 2000) begin
            rd(4'h1, s);
            n++;
        end
        if (n >= 2000) chk("busy", s, 8'h00);
    endtask
    task automatic rst_chk();
        rd(4'h3, s);
        chk("pins", s, 8'h80);
        rd(4'h1, s);
        chk("status", s & 8'h07, 8'h00);
        chk("devreset", {7'h00, dev_rst_n}, 8'h01);
        $display("test reset done");
    endtask
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rst_chk();
        wr(4'h3, 8'h85);
        foreach (rows[i]) begin
            xfer(rows[i].op, rows[i].ptr, rows[i].val);
            chk("status", s & 8'h07, 8'h04);
            rd(4'h2, s);
            if (rows[i].op != 2'h0) chk("rdata", s, rows[i].val);
        end
        $display("test table done");
        flip <= 3'h1;
        xfer(2'h0, 8'h10, 8'h00);
        chk("nack", s & 8'h02, 8'h02);
        flip <= 3'h0;
        $display("test nack done");
        wr(4'h3, 8'hA5);
        repeat (2) @(negedge clk_in);
        chk("pinsout", {en, ch, 2'h0, sel}, 8'hA5);
        repeat (20) @(posedge clk_in);
        xfer(2'h1, 8'h10, 8'h00);
        rd(4'h2, s);
        chk("cleared", s, 8'h00);
        xfer(2'h1, 8'h00, 8'h00);
        rd(4'h2, s);
        chk("fromPins", s, 8'h41);
        wr(4'h3, 8'h25);
        xfer(2'h1, 8'h00, 8'h00);
        rd(4'h2, s);
        chk("serialWins", s, 8'h41);
        chk("applied", swctl_dev_model_inst.live, 8'h41);
        $display("test channel done");
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rst_chk();
        results();
    end

    initial begin
        #400000;
        miscompares++;
        results();
    end
endmodule // switch_control_interface_tb_top
`default_nettype wire
